// ---- design/pse_port_detect_classify_seq.sv ----
// Four-port detection, classification and power-on sequencer
// ----------------------------------------------------------------
// Functional notes
// - Forced-current slope first; forced-voltage point only if slope valid.
// - Detect good needs both forced-current and forced-voltage valid.
// - Resistance between 17k and 29k encodes detect good.
// - Below 1V on first forced-current point aborts with short.
// - Encode unknown, short, low, high, open, cap high, out of range.
// - Manual: idle until detect command, run once, report, idle.
// - Semi-auto: repeat detection, update status, never power unasked.
// - Semi-auto: valid signature with class enable runs classification.
// - Semi-auto wait 100ms between cycles, 2s with midspan.
// - High power semi-auto: power-on only when detect good, else fault.
// - Not high power: power-on command powers regardless of result.
// - Auto mode: powers itself after good detect, sets thresholds.
// - Detection inhibited: strap low at reset, shutdown, detect disabled.
// - Legacy large-capacitance detect off by default, counts as good.
// - Classification: 18V for 12ms, record class; auto or on command.
// - Class codes 0..4; class 0 handled like class 3.
// - Classification inhibited: strap low, shutdown, class enable clear.
// - Two-event with class 4: mark, pause, set second bit, reclassify.
// - Second cycle only after class 4; else Type 1.
// - Auto: class 4 then 0..3 withholds power, restarts detection.
// - Class field holds last pulse; separate bit records second pulse.
// - Threshold writes accepted while a port is powered.
// - Reset and resample straps on reset pin or reset-all bit.
// - Auto thresholds per class: 112/206/375/638 and 425/850 mA.
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "pse_seq_consts.svh"
module pse_port_detect_classify_seq (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          clk_en,
   input  wire logic          standalone_pin,
   input  wire logic          midspan_pin,
   // Analog front end, one measurement strobe per port
   input  wire logic [3:0]    meas_done,
   input  wire logic [67:0]   signature_resistance,
   input  wire logic [55:0]   port_voltage_mv,
   input  wire logic [55:0]   device_capacitance,
   input  wire logic [11:0]   measured_class,
   output logic [3:0]         force_current,
   output logic [3:0]         force_voltage,
   output logic [3:0]         class_drive,
   output logic [3:0]         mark_drive,
   output logic [3:0]         port_output_pin,
   output logic [3:0]         inrush_timeout,
   output logic [39:0]        overload_threshold,
   output logic [39:0]        current_limit_threshold,
   // AXI4-Lite slave
   input  wire logic [7:0]    s_awaddr,
   input  wire logic          s_awvalid,
   output logic               s_awready,
   input  wire logic [31:0]   s_wdata,
   input  wire logic [3:0]    s_wstrb,
   input  wire logic          s_wvalid,
   output logic               s_wready,
   output logic [1:0]         s_bresp,
   output logic               s_bvalid,
   input  wire logic          s_bready,
   input  wire logic [7:0]    s_araddr,
   input  wire logic          s_arvalid,
   output logic               s_arready,
   output logic [31:0]        s_rdata,
   output logic [1:0]         s_rresp,
   output logic               s_rvalid,
   input  wire logic          s_rready
);
   import pse_seq_pkg::*;

   localparam int CLASS_CYC  = `CYC(`CLASS_US);
   localparam int BACK_CYC   = `CYC(`BACKOFF_US);
   localparam int MBACK_CYC  = `CYC(`MID_BACKOFF_US);

   // ----------------------------------------------------------------
   // Strap synchronisers and sampling
   // ----------------------------------------------------------------
   logic [2:0] auto_sync_ff, mid_sync_ff;
   logic       auto_strap_ff, mid_strap_ff, resample_ff, soft_rst_ff;
   logic [2:0] nxt_auto_sync, nxt_mid_sync;
   logic       nxt_auto_strap, nxt_mid_strap, nxt_resample;
   logic       nxt_soft_rst;
   logic       rst_all;
   logic [1:0] fill_ff, nxt_fill;

   // Reset-all bit acts like the pin, one cycle later
   assign rst_all = !aresetn || soft_rst_ff;

   always_comb
   begin
      nxt_auto_sync  = {auto_sync_ff[1:0], standalone_pin};
      nxt_mid_sync   = {mid_sync_ff[1:0], midspan_pin};
      nxt_auto_strap = auto_strap_ff;
      nxt_mid_strap  = mid_strap_ff;
      nxt_resample   = 1'b0;
      nxt_fill       = fill_ff;
      if (fill_ff != `SYNC_FILL)
         nxt_fill = fill_ff + 2'h1;
      // strap capture once chain holds pin samples
      if (resample_ff && fill_ff == `SYNC_FILL
          && auto_sync_ff[2] == auto_sync_ff[1]
          && mid_sync_ff[2] == mid_sync_ff[1])
      begin
         nxt_auto_strap = auto_sync_ff[2];
         nxt_mid_strap  = mid_sync_ff[2];
      end
      else if (resample_ff)
         nxt_resample = 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (rst_all)
      begin
         auto_sync_ff  <= 3'h0;
         mid_sync_ff   <= 3'h0;
         auto_strap_ff <= 1'b0;
         mid_strap_ff  <= 1'b0;
         resample_ff   <= 1'b1;
         fill_ff       <= 2'h0;
      end
      else if (clk_en)
      begin
         auto_sync_ff  <= nxt_auto_sync;
         mid_sync_ff   <= nxt_mid_sync;
         auto_strap_ff <= nxt_auto_strap;
         mid_strap_ff  <= nxt_mid_strap;
         resample_ff   <= nxt_resample;
         fill_ff       <= nxt_fill;
      end
   end

   // ----------------------------------------------------------------
   // Register file and AXI4-Lite slave
   // ----------------------------------------------------------------
   // CTRL: [3:0] det_en [7:4] cls_en [11:8] hp_en [15:12] two_ev
   //       [19:16] legacy_en
   logic [19:0] ctrl_ff, nxt_ctrl;
   logic [7:0]  mode_ff, nxt_mode;
   logic [39:0] ocut_ff, nxt_ocut;   // host overload thresholds
   logic [39:0] olim_ff, nxt_olim;   // host limit thresholds
   logic [3:0]  cmd_det, cmd_cls, cmd_on, cmd_off;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        aw_ff, w_ff, b_ff, r_ff;
   logic        nxt_aw, nxt_w, nxt_b, nxt_r;
   logic [7:0]  awaddr_ff, nxt_awaddr;
   logic [31:0] wdata_ff, nxt_wdata;
   logic [1:0]  bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic        do_wr;
   logic [2:0]  det_ff [4];
   logic [2:0]  cls_ff [4];
   logic [3:0]  second_ff, on_ff;

   assign do_wr = aw_ff && w_ff && !b_ff;

   always_comb
   begin
      nxt_aw = aw_ff;
      nxt_w = w_ff;
      nxt_b = b_ff;
      nxt_r = r_ff;
      nxt_awaddr = awaddr_ff;
      nxt_wdata = wdata_ff;
      nxt_bresp = bresp_ff;
      nxt_rresp = rresp_ff;
      nxt_rdata = rdata_ff;
      nxt_ctrl = ctrl_ff;
      nxt_mode = mode_ff;
      nxt_ocut = ocut_ff;
      nxt_olim = olim_ff;
      nxt_soft_rst = 1'b0;
      cmd_det = 4'h0;
      cmd_cls = 4'h0;
      cmd_on = 4'h0;
      cmd_off = 4'h0;
      if (s_awvalid && !aw_ff)
      begin
         nxt_aw = 1'b1;
         nxt_awaddr = s_awaddr;
      end
      if (s_wvalid && !w_ff)
      begin
         nxt_w = 1'b1;
         nxt_wdata = s_wdata;
      end
      if (do_wr)
      begin
         nxt_b = 1'b1;
         nxt_bresp = 2'b00;
         unique case (awaddr_ff)
            `REG_CTRL:  nxt_ctrl = wdata_ff[19:0];
            `REG_MODE:  nxt_mode = wdata_ff[7:0];
            `REG_CMD:
            begin
               cmd_det = wdata_ff[3:0];
               cmd_cls = wdata_ff[7:4];
               cmd_on  = wdata_ff[11:8];
               cmd_off = wdata_ff[15:12];
            end
            `REG_THRESH0, `REG_THRESH0 + `REG_PORT_STEP,
            `REG_THRESH0 + 8'h08, `REG_THRESH0 + 8'h0c:
            begin
               nxt_ocut[awaddr_ff[3:2]*10 +: 10] = wdata_ff[9:0];
               nxt_olim[awaddr_ff[3:2]*10 +: 10] = wdata_ff[25:16];
            end
            `REG_RESET: nxt_soft_rst = wdata_ff[0];
            default:    nxt_bresp = 2'b10;
         endcase
      end
      if (b_ff && s_bready)
      begin
         nxt_b = 1'b0;
         nxt_aw = 1'b0;
         nxt_w = 1'b0;
      end
      if (s_arvalid && !r_ff)
      begin
         nxt_r = 1'b1;
         nxt_rresp = 2'b00;
         nxt_rdata = 32'h0;
         unique case (s_araddr)
            `REG_CTRL: nxt_rdata = {12'h0, ctrl_ff};
            `REG_MODE: nxt_rdata = {24'h0, mode_ff};
            `REG_CMD, `REG_RESET: nxt_rdata = 32'h0;
            `REG_STAT0, `REG_STAT0 + `REG_PORT_STEP,
            `REG_STAT0 + 8'h08, `REG_STAT0 + 8'h0c:
               nxt_rdata = {22'h0, on_ff[s_araddr[3:2]],
                  second_ff[s_araddr[3:2]], 1'b0, cls_ff[s_araddr[3:2]],
                  1'b0, det_ff[s_araddr[3:2]]};
            `REG_THRESH0, `REG_THRESH0 + `REG_PORT_STEP,
            `REG_THRESH0 + 8'h08, `REG_THRESH0 + 8'h0c:
               nxt_rdata = {6'h0,
                  current_limit_threshold[s_araddr[3:2]*10 +: 10], 6'h0,
                  overload_threshold[s_araddr[3:2]*10 +: 10]};
            default: nxt_rresp = 2'b10;
         endcase
      end
      else if (r_ff && s_rready)
         nxt_r = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (rst_all)
      begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         b_ff <= 1'b0;
         r_ff <= 1'b0;
         awaddr_ff <= 8'h0;
         wdata_ff <= 32'h0;
         bresp_ff <= 2'b00;
         rresp_ff <= 2'b00;
         rdata_ff <= 32'h0;
         ctrl_ff <= 20'h0;
         mode_ff <= 8'h0;
         ocut_ff <= {4{`OVERLOAD_THRESHOLD_C3}};
         olim_ff <= {4{`CURRENT_LIMIT_THRESHOLD_T1}};
         soft_rst_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         aw_ff <= nxt_aw;
         w_ff <= nxt_w;
         b_ff <= nxt_b;
         r_ff <= nxt_r;
         awaddr_ff <= nxt_awaddr;
         wdata_ff <= nxt_wdata;
         bresp_ff <= nxt_bresp;
         rresp_ff <= nxt_rresp;
         rdata_ff <= nxt_rdata;
         ctrl_ff <= nxt_ctrl;
         mode_ff <= nxt_mode;
         ocut_ff <= nxt_ocut;
         olim_ff <= nxt_olim;
         soft_rst_ff <= nxt_soft_rst;
      end
   end

   assign s_awready = !aw_ff;
   assign s_wready  = !w_ff;
   assign s_bvalid  = b_ff;
   assign s_bresp   = bresp_ff;
   assign s_arready = !r_ff;
   assign s_rvalid  = r_ff;
   assign s_rdata   = rdata_ff;
   assign s_rresp   = rresp_ff;

   // ----------------------------------------------------------------
   // Per-port sequencers
   // ----------------------------------------------------------------
   // independent state per port
   genvar p;
   generate
      for (p = 0; p < 4; p++)
      begin : g_port
         seq_state_e  st_ff, nxt_st;
         logic [31:0] cnt_ff, nxt_cnt;
         logic [2:0]  det_n, cls_n;
         logic        sec_n, on_n, flt_ff, nxt_flt, manual_ff, nxt_manual;
         logic        fi_ok_ff, nxt_fi_ok, first4_ff, nxt_first4;
         logic [9:0]  acut_ff, nxt_acut, alim_ff, nxt_alim;
         logic [16:0] r;
         logic [13:0] v, c;
         logic [2:0]  mc, rcode;
         op_mode_e    md;
         logic        det_ok, cls_ok, auto_md;

         assign r  = signature_resistance[p*17 +: 17];
         assign v  = port_voltage_mv[p*14 +: 14];
         assign c  = device_capacitance[p*14 +: 14];
         assign mc = measured_class[p*3 +: 3];
         assign md = op_mode_e'(mode_ff[p*2 +: 2]);
         assign det_ok = auto_strap_ff && md != MODE_SHUT && ctrl_ff[p];
         assign cls_ok = auto_strap_ff && md != MODE_SHUT && ctrl_ff[4+p];
         assign auto_md = md == MODE_AUTO;

         always_comb
         begin
            if (v > `V_RANGE_MAX)
               rcode = `DET_RANGE;
            else if (c > `C_HIGH_MIN)
               rcode = ctrl_ff[16+p] ? `DET_GOOD : `DET_CAP_HIGH;
            else if (r < `R_SHORT_MAX)
               rcode = `DET_SHORT;
            else if (r < `R_GOOD_MIN)
               rcode = `DET_LOW;
            else if (r <= `R_GOOD_MAX)
               rcode = `DET_GOOD;
            else if (r > `R_OPEN_MIN)
               rcode = `DET_OPEN;
            else
               rcode = `DET_HIGH;
         end

         always_comb
         begin
            nxt_st = st_ff;
            nxt_cnt = cnt_ff;
            det_n = det_ff[p];
            cls_n = cls_ff[p];
            sec_n = second_ff[p];
            on_n = on_ff[p];
            nxt_flt = 1'b0;
            nxt_manual = manual_ff;
            nxt_fi_ok = fi_ok_ff;
            nxt_first4 = first4_ff;
            nxt_acut = acut_ff;
            nxt_alim = alim_ff;
            // Host off yields to any state step or ST_POWER power-on in the same cycle
            if (cmd_off[p])
            begin
               on_n = 1'b0;
               nxt_st = ST_IDLE;
            end
            else if (cmd_on[p] && md != MODE_SHUT && !on_ff[p])
            begin
               if (ctrl_ff[8+p] && det_ff[p] != `DET_GOOD)
                  nxt_flt = 1'b1;
               else
                  on_n = 1'b1;
            end
            unique case (st_ff)
               ST_IDLE:
               begin
                  nxt_manual = md == MODE_MANUAL;
                  // manual waits for a command; semi repeats
                  if (!on_ff[p] && det_ok && (md == MODE_SEMI || auto_md
                      || (md == MODE_MANUAL && cmd_det[p])))
                  begin
                     nxt_st = ST_FI;
                     det_n = `DET_UNKNOWN;
                     nxt_fi_ok = 1'b0;
                  end
                  else if (md == MODE_MANUAL && cmd_cls[p] && cls_ok)
                  begin
                     nxt_st = ST_CLASS;
                     nxt_cnt = 32'h0;
                     sec_n = 1'b0;
                     nxt_first4 = 1'b0;
                  end
               end
               ST_FI:
                  if (meas_done[p])
                  begin
                     // abort on short at first point
                     if (!fi_ok_ff && v < `V_SHORT_MAX)
                     begin
                        det_n = `DET_SHORT;
                        nxt_st = ST_WAIT;
                     end
                     else if (!fi_ok_ff)
                        nxt_fi_ok = 1'b1;
                     // forced voltage only after valid slope
                     else if (rcode == `DET_GOOD)
                        nxt_st = ST_FV;
                     else
                     begin
                        det_n = rcode;
                        nxt_st = ST_WAIT;
                     end
                     nxt_cnt = 32'h0;
                  end
               ST_FV:
                  if (meas_done[p])
                  begin
                     det_n = rcode;
                     nxt_cnt = 32'h0;
                     sec_n = 1'b0;
                     nxt_first4 = 1'b0;
                     if (rcode == `DET_GOOD && cls_ok && !nxt_manual)
                        nxt_st = ST_CLASS;
                     else if (rcode == `DET_GOOD && auto_md)
                        nxt_st = ST_POWER;
                     else
                        nxt_st = ST_WAIT;
                  end
               ST_CLASS:
               begin
                  nxt_cnt = cnt_ff + 32'h1;
                  if (cnt_ff == 32'(CLASS_CYC - 1))
                  begin
                     // class field is the last pulse
                     cls_n = mc;
                     nxt_cnt = 32'h0;
                     // second event only after class 4
                     if (ctrl_ff[12+p] && mc == 3'h4 && !sec_n)
                     begin
                        nxt_first4 = 1'b1;
                        nxt_st = ST_MARK;
                     end
                     // class 4 then lower: no power
                     else if (auto_md && det_ff[p] == `DET_GOOD
                              && !(first4_ff && mc != 3'h4))
                        nxt_st = ST_POWER;
                     else
                        nxt_st = nxt_manual ? ST_IDLE : ST_WAIT;
                  end
               end
               ST_MARK:
               begin
                  nxt_cnt = cnt_ff + 32'h1;
                  if (cnt_ff == `MARK_PAUSE_CYC - 32'h1)
                  begin
                     sec_n = 1'b1;
                     nxt_cnt = 32'h0;
                     nxt_st = ST_CLASS;
                  end
               end
               ST_WAIT:
               begin
                  nxt_cnt = cnt_ff + 32'h1;
                  // manual returns to idle at once
                  if (nxt_manual)
                     nxt_st = ST_IDLE;
                  else if (cnt_ff >= 32'(mid_strap_ff ? MBACK_CYC - 1
                                               : BACK_CYC - 1))
                     nxt_st = ST_IDLE;
               end
               ST_POWER:
               begin
                  on_n = 1'b1;
                  nxt_alim = cls_ff[p] == 3'h4 ? `CURRENT_LIMIT_THRESHOLD_T2 : `CURRENT_LIMIT_THRESHOLD_T1;
                  unique case (cls_ff[p])
                     3'h1:    nxt_acut = `OVERLOAD_THRESHOLD_C1;
                     3'h2:    nxt_acut = `OVERLOAD_THRESHOLD_C2;
                     3'h4:    nxt_acut = `OVERLOAD_THRESHOLD_C4;
                     default: nxt_acut = `OVERLOAD_THRESHOLD_C3;
                  endcase
                  nxt_st = ST_IDLE;
               end
               default: nxt_st = ST_IDLE;
            endcase
            if (md == MODE_SHUT)
            begin
               on_n = 1'b0;
               nxt_st = ST_IDLE;
            end
         end

         always_ff @(posedge aclk)
         begin
            if (rst_all)
            begin
               st_ff <= ST_IDLE;
               cnt_ff <= 32'h0;
               det_ff[p] <= `DET_UNKNOWN;
               cls_ff[p] <= 3'h0;
               second_ff[p] <= 1'b0;
               on_ff[p] <= 1'b0;
               flt_ff <= 1'b0;
               manual_ff <= 1'b0;
               fi_ok_ff <= 1'b0;
               first4_ff <= 1'b0;
               acut_ff <= `OVERLOAD_THRESHOLD_C3;
               alim_ff <= `CURRENT_LIMIT_THRESHOLD_T1;
            end
            else if (clk_en)
            begin
               st_ff <= nxt_st;
               cnt_ff <= nxt_cnt;
               det_ff[p] <= det_n;
               cls_ff[p] <= cls_n;
               second_ff[p] <= sec_n;
               on_ff[p] <= on_n;
               flt_ff <= nxt_flt;
               manual_ff <= nxt_manual;
               fi_ok_ff <= nxt_fi_ok;
               first4_ff <= nxt_first4;
               acut_ff <= nxt_acut;
               alim_ff <= nxt_alim;
            end
         end

         // Drives are decoded from state registers only
         assign force_current[p] = st_ff == ST_FI;
         assign force_voltage[p] = st_ff == ST_FV;
         assign class_drive[p] = st_ff == ST_CLASS;
         assign mark_drive[p] = st_ff == ST_MARK;
         assign port_output_pin[p] = on_ff[p];
         assign inrush_timeout[p] = flt_ff;
         // Auto mode with auto strap high selects automatic thresholds
         assign overload_threshold[p*10 +: 10] =
            (auto_md && auto_strap_ff) ? acut_ff : ocut_ff[p*10 +: 10];
         assign current_limit_threshold[p*10 +: 10] =
            (auto_md && auto_strap_ff) ? alim_ff : olim_ff[p*10 +: 10];
      end
   endgenerate
endmodule // pse_port_detect_classify_seq

// ---- design/pse_seq_consts.svh ----
// Constants for the four-port detect and classify sequencer
`ifndef PSE_SEQ_CONSTS_SVH
`define PSE_SEQ_CONSTS_SVH
// Register byte offsets
`define REG_CTRL        8'h00
`define REG_MODE        8'h04
`define REG_CMD         8'h08
`define REG_STAT0       8'h10
`define REG_THRESH0     8'h20
`define REG_RESET       8'h30
`define REG_PORT_STEP   8'h04
// Detect result codes
`define DET_UNKNOWN     3'h0
`define DET_SHORT       3'h1
`define DET_CAP_HIGH    3'h2
`define DET_LOW         3'h3
`define DET_GOOD        3'h4
`define DET_HIGH        3'h5
`define DET_OPEN        3'h6
`define DET_RANGE       3'h7
// Resistance thresholds in ohms, 17-bit measurement
`define R_SHORT_MAX     17'd2400
`define R_GOOD_MIN      17'd17000
`define R_GOOD_MAX      17'd29000
`define R_OPEN_MIN      17'd50000
// Voltage in mV, capacitance in nF
`define V_SHORT_MAX     14'd1000
`define V_RANGE_MAX     14'd10000
`define C_HIGH_MIN      14'd2700
// Overload / limit thresholds in mA
`define OVERLOAD_THRESHOLD_C1         10'd112
`define OVERLOAD_THRESHOLD_C2         10'd206
`define OVERLOAD_THRESHOLD_C3         10'd375
`define OVERLOAD_THRESHOLD_C4         10'd638
`define CURRENT_LIMIT_THRESHOLD_T1         10'd425
`define CURRENT_LIMIT_THRESHOLD_T2         10'd850
// Times at 250 MHz
`define CLK_MHZ         250
`define CLASS_US        12000
`define BACKOFF_US      100000
`define MID_BACKOFF_US  2000000
`define MARK_PAUSE_CYC  32'd2500
`define SYNC_FILL       2'h3
`define CYC(us)         ((us) * `CLK_MHZ)
`endif

// ---- design/pse_seq_pkg.sv ----
// Types for the detect and classify sequencer
package pse_seq_pkg;
   typedef enum logic [1:0] {MODE_SHUT, MODE_MANUAL, MODE_SEMI, MODE_AUTO}
      op_mode_e;
   typedef enum logic [2:0] {
      ST_IDLE, ST_FI, ST_FV, ST_CLASS, ST_MARK, ST_WAIT, ST_POWER
   } seq_state_e;
   typedef logic [2:0] det_t;
   typedef logic [2:0] class_t;
endpackage

// ---- testbench/pd_model.sv ----
// Attached device model answering forced test points
`timescale 1ns/10ps
module pd_model (
   input wire logic        aclk,
   input wire logic [3:0]  force_current,
   input wire logic [3:0]  force_voltage,
   input wire logic [16:0] res,
   input wire logic [13:0] volt,
   input wire logic [13:0] cap,
   output logic [3:0]      meas_done,
   output logic [67:0]     signature_resistance,
   output logic [55:0]     port_voltage_mv,
   output logic [55:0]     device_capacitance,
   output logic [11:0]     measured_class
);
   logic [1:0] cnt_ff [4];
   logic       v;
   // Off-strobe values garbled, never stale
   assign v = |meas_done;
   assign signature_resistance = {4{v ? res : ~res}};
   assign port_voltage_mv = {4{v ? volt : ~volt}};
   assign device_capacitance = {4{v ? cap : ~cap}};
   assign measured_class = {4{v ? 3'h3 : 3'h4}};
   always_ff @(posedge aclk)
      for (int p = 0; p < 4; p++)
      begin
         cnt_ff[p] <= (force_current[p] | force_voltage[p]) ?
            cnt_ff[p] + 2'h1 : 2'h0;
         meas_done[p] <= cnt_ff[p] == 2'h3;
      end
endmodule // pd_model

// ---- testbench/pse_seq_properties.sv ----
// Port checker for the sequencer
`timescale 1ns/10ps
module pse_seq_properties (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic [3:0] force_current,
   input wire logic [3:0] force_voltage,
   input wire logic [3:0] class_drive,
   input wire logic [3:0] mark_drive,
   input wire logic [3:0] port_output_pin,
   input wire logic [3:0] inrush_timeout,
   input wire logic       s_arvalid,
   input wire logic       s_arready,
   input wire logic       s_rvalid,
   input wire logic       s_rready
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence rd_taken; s_arvalid && s_arready; endsequence
   fc_fv_excl_a: assert property (!(|(force_current & force_voltage)))
      else $error("both forced");
   fv_order_a: assert property ($rose(force_voltage[0]) |->
      $past(force_current[0])) else $error("voltage before current");
   mark_order_a: assert property ($rose(mark_drive[0]) |->
      $past(class_drive[0])) else $error("mark without class");
   class_excl_a: assert property (!(|(class_drive & force_current)))
      else $error("class during detect");
   fault_off_a: assert property (inrush_timeout[1] |=>
      !port_output_pin[1] && !inrush_timeout[1]) else $error("fault power");
   rd_lat_a: assert property (rd_taken |=> s_rvalid)
      else $error("late read");
   rd_drop_a: assert property (s_rvalid && s_rready |=> !s_rvalid)
      else $error("read stuck");
   rd_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid)
      else $error("read dropped");
endmodule // pse_seq_properties
bind pse_port_detect_classify_seq pse_seq_properties pse_seq_properties_inst
   (.aclk, .aresetn, .force_current, .force_voltage, .class_drive,
   .mark_drive, .port_output_pin, .inrush_timeout, .s_arvalid,
   .s_arready, .s_rvalid, .s_rready);

// ---- testbench/tb_pse_port_detect_classify_seq.sv ----
// Self-checking bench for the sequencer
`timescale 1ns/10ps
module tb_pse_port_detect_classify_seq;
   logic aclk = 0, aresetn = 0, s_awvalid = 0, s_wvalid = 0, s_bready = 0;
   logic s_arvalid = 0, s_rready = 0, s_awready, s_wready, s_bvalid;
   logic s_arready, s_rvalid, fault_seen = 0;
   logic [7:0] s_awaddr = 8'h0, s_araddr = 8'h0;
   logic [31:0] s_wdata = 32'h0, s_rdata, rd;
   logic [1:0] s_bresp, s_rresp, rr;
   logic [3:0] meas_done, force_current, force_voltage, class_drive;
   logic [3:0] mark_drive, port_output_pin, inrush_timeout;
   logic [67:0] signature_resistance;
   logic [55:0] port_voltage_mv, device_capacitance;
   logic [11:0] measured_class;
   logic [39:0] overload_threshold, current_limit_threshold;
   logic [16:0] res = 17'h0;
   logic [13:0] volt = 14'h0, cap = 14'h0;
   logic [2:0] want;
   int err_count = 0, tests_run = 0;
   logic [47:0] rows [8] = '{{17'h61a8, 14'h1388, 14'h64, 3'h4},
      {17'h3e8, 14'h1388, 14'h64, 3'h1}, {17'h2710, 14'h1388, 14'h64, 3'h3},
      {17'h88b8, 14'h1388, 14'h64, 3'h5}, {17'h61a8, 14'h1f4, 14'h64, 3'h1},
      {17'h61a8, 14'h2ee0, 14'h64, 3'h7}, {17'h61a8, 14'h1388, 14'hbb8, 3'h2},
      {17'hea60, 14'h1388, 14'h64, 3'h6}};
   pse_port_detect_classify_seq pse_port_detect_classify_seq_inst (.aclk,
      .aresetn, .clk_en(1'b1), .standalone_pin(1'b1), .midspan_pin(1'b0),
      .meas_done, .signature_resistance, .port_voltage_mv,
      .device_capacitance, .measured_class, .force_current, .force_voltage,
      .class_drive, .mark_drive, .port_output_pin, .inrush_timeout,
      .overload_threshold, .current_limit_threshold, .s_awaddr, .s_awvalid,
      .s_awready, .s_wdata, .s_wstrb(4'hf), .s_wvalid, .s_wready, .s_bresp,
      .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
      .s_rresp, .s_rvalid, .s_rready);
   pd_model pd_model_inst (.aclk, .force_current, .force_voltage, .res,
      .volt, .cap, .meas_done, .signature_resistance, .port_voltage_mv,
      .device_capacitance, .measured_class);
   always #2 aclk = ~aclk;
   always @(posedge aclk)
      if (inrush_timeout[1]) fault_seen <= 1'b1;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      {s_awaddr, s_wdata, s_awvalid, s_wvalid, s_bready} <= {a, d, 3'h7};
      do
      begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'b0;
         if (s_wready) s_wvalid <= 1'b0;
      end while (!s_bvalid);
      s_bready <= 1'b0;
   endtask
   task rdr(input logic [7:0] a);
      @(posedge aclk);
      {s_araddr, s_arvalid, s_rready} <= {a, 2'h3};
      do
      begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'b0;
      end while (!s_rvalid);
      {rd, rr} = {s_rdata, s_rresp};
      s_rready <= 1'b0;
   endtask
   // Fixed wait covers two current and one voltage point
   task det(input logic [47:0] row);
      {res, volt, cap, want} <= row;
      wr(8'h08, 32'h1);
      repeat (40) @(posedge aclk);
      rdr(8'h10);
      chk(rd[2:0], want);
   endtask
   task results();
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #200000;
      err_count++;
      results();
   end
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      rdr(8'h10);
      chk(rd[2:0], 3'h0);
      chk(current_limit_threshold[9:0], 10'h1a9);
      wr(8'h00, 32'h10201);
      wr(8'h04, 32'h9);
      det({17'h61a8, 14'h1388, 14'hbb8, 3'h4});
      wr(8'h00, 32'h201);
      foreach (rows[i])
         det(rows[i]);
      wr(8'h08, 32'h100);
      repeat (20) @(posedge aclk);
      chk(port_output_pin, 4'h1);
      wr(8'h08, 32'h200);
      repeat (20) @(posedge aclk);
      chk({fault_seen, port_output_pin[1]}, 2'h2);
      rdr(8'h14);
      chk(rd[2:0], 3'h0);
      wr(8'h20, 32'h352027e);
      chk({current_limit_threshold[9:0],
         overload_threshold[9:0]}, 20'hd4a7e);
      rdr(8'h3c);
      chk(rr, 2'h2);
      results();
   end
endmodule // tb_pse_port_detect_classify_seq
